// ==== hw/quadrature_wheel_decoder.sv ====
// Operation
// - Each phase picks one of eight pins
// - Mode bit chooses common or double; resets double
// - Common mode counts once per full step
// - Double mode counts every phase edge
// - Counter hidden; count register changes only on load or on a clearing read
// - Load bit copies counter, then self-clears
// - Reading count returns value, then clears it
// - Decoder reset bit clears the internal counter
// - Filter field sets debounce window, drops jitter
// - Levels under 3*2^(n+1) slow periods are jitter
// - Inputs sampled every 2^n slow periods
// - Polarity bit defines the idle input level
// - Shuttle bit accepts non-overlapping phase pulses
// - Logic runs on the 32 kHz slow clock enable
`timescale 1ns/1ps
`default_nettype none
module quadrature_wheel_decoder
    import wheel_decoder_pkg::*;
#(
    parameter int SLOW_DIVIDE = SLOW_DIV,
    parameter int WINDOW_SAMPLES = FILTER_SAMPLES
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [PIN_COUNT-1:0] PHASE_PIN,
    output logic [DATA_W-1:0] RDATA
);

    decode_cfg_s cfg;
    logic [FILTER_N_W-1:0] filter_n;
    logic polarity;
    logic shuttle;
    logic double_mode;
    logic [PIN_SEL_W-1:0] phase_a_pin;
    logic [PIN_SEL_W-1:0] phase_b_pin;
    logic load_pending;
    logic decoder_reset;
    logic [7:0] count_value;
    logic [7:0] wheel_count;

    logic [PIN_COUNT-1:0] pin_sync1;
    logic [PIN_COUNT-1:0] pin_sync2;
    logic [PIN_COUNT-1:0] pin_sync3;
    logic [PIN_COUNT-1:0] pin_level;

    logic raw_a;
    logic raw_b;
    logic sample_tick;
    phase_edge_s edge_a;
    phase_edge_s edge_b;
    quad_e prev_quad;
    quad_e cur_quad;
    logic step_up;
    logic step_down;
    logic shuttle_up;
    logic shuttle_down;
    logic double_up;
    logic double_down;
    logic common_up;
    logic common_down;

    logic wr_hit_filter;
    logic wr_hit_mode;
    logic wr_hit_load;
    logic wr_hit_pin_a;
    logic wr_hit_pin_b;
    logic wr_hit_reset;
    logic rd_hit_count;
    logic [DATA_W-1:0] next_rdata;

    // Address decode of the strobes
    assign wr_hit_filter = WR && (ADDR == OFF_FILTER_POLARITY_SHUTTLE);
    assign wr_hit_mode = WR && (ADDR == OFF_COUNT_MODE_SELECT);
    assign wr_hit_load = WR && (ADDR == OFF_COUNT_LOAD_REQUEST);
    assign wr_hit_pin_a = WR && (ADDR == OFF_PHASE_A_PIN_SELECT);
    assign wr_hit_pin_b = WR && (ADDR == OFF_PHASE_B_PIN_SELECT);
    assign wr_hit_reset = WR && (ADDR == OFF_SYSTEM_RESET);
    assign rd_hit_count = RD && (ADDR == OFF_WHEEL_COUNT);

    // Debounce window length
    // Shrinking it restarts the sample count at the next slow tick
    always_ff @(posedge MCLK) begin
        if (RST) begin
            filter_n <= RST_FILTER_N;
        end else if (wr_hit_filter) begin
            filter_n <= WDATA[FILTER_N_LSB +: FILTER_N_W];
        end
    end

    // Idle level of the phase pins
    // Flip it only while the wheel rests, or one step may be miscounted
    always_ff @(posedge MCLK) begin
        if (RST) begin
            polarity <= RST_POLARITY;
        end else if (wr_hit_filter) begin
            polarity <= WDATA[POLARITY_BIT];
        end
    end

    // Shuttle mode for phase pulses that never overlap
    always_ff @(posedge MCLK) begin
        if (RST) begin
            shuttle <= RST_SHUTTLE;
        end else if (wr_hit_filter) begin
            shuttle <= WDATA[SHUTTLE_BIT];
        end
    end

    // Counting mode; double accuracy after reset
    always_ff @(posedge MCLK) begin
        if (RST) begin
            double_mode <= RST_DOUBLE_MODE;
        end else if (wr_hit_mode) begin
            double_mode <= WDATA[MODE_BIT];
        end
    end

    // One bundle for the decode logic, each field from its own register
    always_comb begin
        cfg.filter_n = filter_n;
        cfg.polarity = polarity;
        cfg.shuttle = shuttle;
        cfg.double_mode = double_mode;
    end

    // Pin selection for phase a
    always_ff @(posedge MCLK) begin
        if (RST) begin
            phase_a_pin <= RST_PHASE_A_PIN;
        end else if (wr_hit_pin_a) begin
            phase_a_pin <= WDATA[PIN_SEL_W-1:0];
        end
    end

    // Pin selection for phase b
    always_ff @(posedge MCLK) begin
        if (RST) begin
            phase_b_pin <= RST_PHASE_B_PIN;
        end else if (wr_hit_pin_b) begin
            phase_b_pin <= WDATA[PIN_SEL_W-1:0];
        end
    end

    // Decoder reset bit is a level; the counter stays at zero while it is set
    // It never clears itself, so software must write zero to release it
    always_ff @(posedge MCLK) begin
        if (RST) begin
            decoder_reset <= RST_DECODER_RESET;
        end else if (wr_hit_reset) begin
            decoder_reset <= WDATA[DECODER_RESET_BIT];
        end
    end

    // Load request; a new request wins over completion in the same cycle
    // Software sees the bit high only in the cycle right after its write
    always_ff @(posedge MCLK) begin
        if (RST) begin
            load_pending <= RST_LOAD;
        end else if (wr_hit_load) begin
            load_pending <= WDATA[LOAD_BIT];
        end else if (load_pending) begin
            load_pending <= 1'b0;
        end
    end

    // Snapshot register: loaded on request, cleared by a read
    // A load in the same cycle as a clearing read wins, so no snapshot is lost
    always_ff @(posedge MCLK) begin
        if (RST) begin
            wheel_count <= RST_COUNT;
        end else if (load_pending) begin
            wheel_count <= count_value;
        end else if (rd_hit_count) begin
            wheel_count <= RST_COUNT;
        end
    end

    // Read mux; unmapped and reserved addresses read zero
    // The mux has no side effect; the clear on read sits with the register
    always_comb begin
        next_rdata = '0;
        unique case (ADDR)
            OFF_WHEEL_COUNT: next_rdata = wheel_count;
            OFF_FILTER_POLARITY_SHUTTLE: begin
                next_rdata[FILTER_N_LSB +: FILTER_N_W] = cfg.filter_n;
                next_rdata[POLARITY_BIT] = cfg.polarity;
                next_rdata[SHUTTLE_BIT] = cfg.shuttle;
            end
            OFF_PHASE_A_PIN_SELECT: next_rdata[PIN_SEL_W-1:0] = phase_a_pin;
            OFF_PHASE_B_PIN_SELECT: next_rdata[PIN_SEL_W-1:0] = phase_b_pin;
            OFF_COUNT_MODE_SELECT: next_rdata[MODE_BIT] = cfg.double_mode;
            OFF_COUNT_LOAD_REQUEST: next_rdata[LOAD_BIT] = load_pending;
            OFF_SYSTEM_RESET: next_rdata[DECODER_RESET_BIT] = decoder_reset;
            default: next_rdata = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    // Zero outside the answer cycle keeps a shared read bus quiet
    always_ff @(posedge MCLK) begin
        if (RST) begin
            RDATA <= '0;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= '0;
        end
    end

    // Pin synchroniser; the first stage feeds only the second
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin_sync1 <= '0;
            pin_sync2 <= '0;
            pin_sync3 <= '0;
        end else begin
            pin_sync1 <= PHASE_PIN;
            pin_sync2 <= pin_sync1;
            pin_sync3 <= pin_sync2;
        end
    end

    // A pin change is accepted once the second and third stages agree
    // A pin that toggles every clock never settles and keeps its last level
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin_level <= '0;
        end else begin
            pin_level <= (pin_sync3 & ~(pin_sync2 ^ pin_sync3))
                | (pin_level & (pin_sync2 ^ pin_sync3));
        end
    end

    // Pin mux and idle polarity; internally the idle level is always low
    // Changing the selection or polarity on the fly may count one false step
    assign raw_a = pin_level[phase_a_pin] ^ cfg.polarity;
    assign raw_b = pin_level[phase_b_pin] ^ cfg.polarity;

    // Slow clock enable and 2^n sampling enable
    // Every filter and window count is reckoned in slow periods
    tick_divider #(
        .DIV(SLOW_DIVIDE)
    ) u_tick_divider (
        .clk(MCLK),
        .rst(RST),
        .filter_n(cfg.filter_n),
        .slow_tick(),
        .sample_tick(sample_tick)
    );

    // Debounce of phase a: level must hold 6 samples of 2^n slow periods
    phase_filter #(
        .SAMPLES(WINDOW_SAMPLES)
    ) u_filter_a (
        .clk(MCLK),
        .rst(RST),
        .sample_tick(sample_tick),
        .raw(raw_a),
        .edges(edge_a)
    );

    // Debounce of phase b, same window
    phase_filter #(
        .SAMPLES(WINDOW_SAMPLES)
    ) u_filter_b (
        .clk(MCLK),
        .rst(RST),
        .sample_tick(sample_tick),
        .raw(raw_b),
        .edges(edge_b)
    );

    assign cur_quad = quad_e'({edge_a.level, edge_b.level});

    // Previous filtered levels for the transition decode
    always_ff @(posedge MCLK) begin
        if (RST) begin
            prev_quad <= Q_NONE;
        end else begin
            prev_quad <= cur_quad;
        end
    end

    // Shuttle steps: pulses on a count up, pulses on b count down
    // In common mode a pulse counts on its trailing edge
    always_comb begin
        shuttle_up = edge_a.fall;
        shuttle_down = edge_b.fall;
        if (cfg.double_mode) begin
            shuttle_up = edge_a.rise | edge_a.fall;
            shuttle_down = edge_b.rise | edge_b.fall;
        end
    end

    // Double accuracy: forward order 00, 10, 11, 01 and back to 00
    always_comb begin
        double_up = 1'b0;
        double_down = 1'b0;
        unique case ({prev_quad, cur_quad})
            {Q_NONE, Q_A_ONLY}, {Q_A_ONLY, Q_BOTH},
            {Q_BOTH, Q_B_ONLY}, {Q_B_ONLY, Q_NONE}: double_up = 1'b1;
            {Q_A_ONLY, Q_NONE}, {Q_BOTH, Q_A_ONLY},
            {Q_B_ONLY, Q_BOTH}, {Q_NONE, Q_B_ONLY}: double_down = 1'b1;
            default: double_up = 1'b0;
        endcase
    end

    // Common mode: count only once both phases show the same edge
    always_comb begin
        common_up = 1'b0;
        common_down = 1'b0;
        unique case ({prev_quad, cur_quad})
            {Q_A_ONLY, Q_BOTH}, {Q_B_ONLY, Q_NONE}: common_up = 1'b1;
            {Q_B_ONLY, Q_BOTH}, {Q_A_ONLY, Q_NONE}: common_down = 1'b1;
            default: common_up = 1'b0;
        endcase
    end

    // Step select; both phases moving at once is ambiguous and ignored
    // Encoder must keep edges apart by a sample window for this to hold
    always_comb begin
        if (cfg.shuttle) begin
            step_up = shuttle_up & ~shuttle_down;
            step_down = shuttle_down & ~shuttle_up;
        end else if (cfg.double_mode) begin
            step_up = double_up;
            step_down = double_down;
        end else begin
            step_up = common_up;
            step_down = common_down;
        end
    end

    // Hidden step counter, 8-bit two's complement with wrap
    // No saturation: software must read often enough to unwrap the value
    always_ff @(posedge MCLK) begin
        if (RST) begin
            count_value <= RST_COUNT;
        end else if (decoder_reset) begin
            count_value <= RST_COUNT;
        end else if (step_up) begin
            count_value <= count_value + 8'h01;
        end else if (step_down) begin
            count_value <= count_value - 8'h01;
        end
    end

endmodule
`default_nettype wire

// ==== hw/wheel_decoder_pkg.sv ====
package wheel_decoder_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFF_WHEEL_COUNT = 8'hD0;
    localparam logic [7:0] OFF_FILTER_POLARITY_SHUTTLE = 8'hD1;
    localparam logic [7:0] OFF_PHASE_A_PIN_SELECT = 8'hD2;
    localparam logic [7:0] OFF_PHASE_B_PIN_SELECT = 8'hD3;
    localparam logic [7:0] OFF_RESERVED_D6 = 8'hD6;
    localparam logic [7:0] OFF_COUNT_MODE_SELECT = 8'hD7;
    localparam logic [7:0] OFF_COUNT_LOAD_REQUEST = 8'hD8;
    localparam logic [7:0] OFF_SYSTEM_RESET = 8'h60;

    // Field positions and widths
    localparam int FILTER_N_LSB = 0;
    localparam int FILTER_N_W = 3;
    localparam int POLARITY_BIT = 4;
    localparam int SHUTTLE_BIT = 5;
    localparam int PIN_SEL_W = 3;
    localparam int PIN_COUNT = 8;
    localparam int MODE_BIT = 0;
    localparam int LOAD_BIT = 0;
    localparam int DECODER_RESET_BIT = 5;

    // Reset values
    localparam logic [2:0] RST_FILTER_N = 3'h0;
    localparam logic RST_POLARITY = 1'b0;
    localparam logic RST_SHUTTLE = 1'b0;
    localparam logic [2:0] RST_PHASE_A_PIN = 3'h0;
    localparam logic [2:0] RST_PHASE_B_PIN = 3'h1;
    localparam logic RST_DOUBLE_MODE = 1'b1;
    localparam logic RST_LOAD = 1'b0;
    localparam logic RST_DECODER_RESET = 1'b0;
    localparam logic [7:0] RST_COUNT = 8'h00;

    // Timing: slow clock is an enable derived from MCLK
    localparam int MCLK_HZ = 20_000_000;
    localparam int SLOW_CLOCK_HZ = 32_000;
    localparam int SLOW_DIV = MCLK_HZ / SLOW_CLOCK_HZ;
    localparam int JITTER_FACTOR = 3;
    // Window of 3*2^(n+1) slow periods expressed in 2^n sample ticks
    localparam int FILTER_SAMPLES = JITTER_FACTOR * 2;

    // Filtered phase levels {a,b}
    typedef enum logic [1:0] {
        Q_NONE = 2'b00,
        Q_B_ONLY = 2'b01,
        Q_A_ONLY = 2'b10,
        Q_BOTH = 2'b11
    } quad_e;

    // Decoder configuration
    typedef struct packed {
        logic [2:0] filter_n;
        logic polarity;
        logic shuttle;
        logic double_mode;
    } decode_cfg_s;

    // Filtered phase with its edge pulses
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } phase_edge_s;

endpackage

// ==== hw/tick_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module tick_divider
    import wheel_decoder_pkg::*;
#(
    parameter int DIV = SLOW_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] filter_n,
    output logic slow_tick,
    output logic sample_tick
);

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] DIV_LAST = CW'(DIV - 1);

    logic [CW-1:0] slow_cnt;
    logic [6:0] window_cnt;
    logic [6:0] window_last;

    // Last window count is 2^n - 1 slow periods
    assign window_last = 7'((8'h01 << filter_n) - 8'h01);

    // Slow clock enable, one MCLK wide
    always_ff @(posedge clk) begin
        if (rst) begin
            slow_cnt <= '0;
            slow_tick <= 1'b0;
        end else if (slow_cnt == DIV_LAST) begin
            slow_cnt <= '0;
            slow_tick <= 1'b1;
        end else begin
            slow_cnt <= slow_cnt + 1'b1;
            slow_tick <= 1'b0;
        end
    end

    // Sampling enable every 2^n slow periods
    always_ff @(posedge clk) begin
        if (rst) begin
            window_cnt <= 7'h00;
            sample_tick <= 1'b0;
        end else begin
            sample_tick <= 1'b0;
            if (slow_tick) begin
                if (window_cnt >= window_last) begin // A shrunk window restarts at once
                    window_cnt <= 7'h00;
                    sample_tick <= 1'b1;
                end else begin
                    window_cnt <= window_cnt + 7'h01;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== hw/phase_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module phase_filter
    import wheel_decoder_pkg::*;
#(
    parameter int SAMPLES = FILTER_SAMPLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sample_tick,
    input wire logic raw,
    output phase_edge_s edges
);

    localparam int RW = $clog2(SAMPLES + 1);
    localparam logic [RW-1:0] RUN_LAST = RW'(SAMPLES - 1);

    logic [RW-1:0] run;

    // A new level is taken only after SAMPLES agreeing samples in a row
    always_ff @(posedge clk) begin
        if (rst) begin
            run <= '0;
            edges <= '0;
        end else begin
            edges.rise <= 1'b0;
            edges.fall <= 1'b0;
            if (sample_tick) begin
                if (raw == edges.level) begin
                    run <= '0; // Short excursion is dropped
                end else if (run == RUN_LAST) begin
                    run <= '0;
                    edges.level <= raw;
                    edges.rise <= raw;
                    edges.fall <= ~raw;
                end else begin
                    run <= run + 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== sim/wheel_decoder_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module wheel_decoder_sva
    import wheel_decoder_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [DATA_W-1:0] RDATA
);
    logic stale;
    logic held;
    logic mode;
    logic load_d;
    logic [7:0] cfg;
    logic [7:0] pin_a;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Shadows of what software wrote, masked to the implemented bits
    always_ff @(posedge MCLK) begin
        if (RST) begin
            mode <= RST_DOUBLE_MODE;
            cfg <= 8'h00;
            pin_a <= 8'h00;
            held <= 1'b0;
        end else if (WR) begin
            if (ADDR == 8'hD7) mode <= WDATA[0];
            if (ADDR == 8'hD1) cfg <= WDATA & 8'h37;
            if (ADDR == 8'hD2) pin_a <= WDATA & 8'h07;
            if (ADDR == 8'h60) held <= WDATA[5];
        end
    end
    // Count register is known zero after a read until the next load
    always_ff @(posedge MCLK) begin
        load_d <= WR && ADDR == 8'hD8 && WDATA[0];
        if (RST) stale <= 1'b1;
        else if (WR && ADDR == 8'hD8 && WDATA[0]) stale <= 1'b0;
        else if (RD && ADDR == 8'hD0 && !load_d) stale <= 1'b1; // Pending load wins
    end
    AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_STALE_ZERO: assert property (RD && ADDR == 8'hD0 && stale |=> RDATA == 8'h00)
        else $error("count register changed without a load");
    AST_LOAD_CLEARS: assert property (WR && ADDR == 8'hD8 ##2 RD && ADDR == 8'hD8 && !$past(WR)
        |=> !RDATA[0])
        else $error("load bit did not clear itself");
    AST_MODE_BACK: assert property (RD && ADDR == 8'hD7 |=> RDATA == {7'h00, mode})
        else $error("mode bit readback wrong");
    AST_PIN_BACK: assert property (RD && ADDR == 8'hD2 |=> RDATA == pin_a)
        else $error("pin select readback wrong");
    AST_CFG_BACK: assert property (RD && ADDR == 8'hD1 |=> RDATA == cfg)
        else $error("filter setup readback wrong");
    AST_HELD_ZERO: assert property (WR && ADDR == 8'hD8 && WDATA[0] && held && $past(held)
        ##2 RD && ADDR == 8'hD0 |=> RDATA == 8'h00)
        else $error("held counter loaded nonzero");
    AST_RSVD_ZERO: assert property (RD && ADDR == 8'hD6 |=> RDATA == 8'h00)
        else $error("reserved register read nonzero");
endmodule
bind quadrature_wheel_decoder wheel_decoder_sva sva_u (.MCLK(MCLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
`default_nettype wire

// ==== sim/wheel_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module wheel_encoder (
    input wire logic clk,
    input wire logic [2:0] sel_a,
    input wire logic [2:0] sel_b,
    input wire logic pol,
    input wire logic [1:0] lvl,
    output logic [7:0] pins
);
    logic [7:0] noise = 8'h55;
    // Unused pins chatter every cycle; the decoder holds such a pin at its last level, so a wrong selection looks quiet
    always_ff @(posedge clk) begin
        noise <= ~noise;
    end
    // Wheel phases land on the chosen pins; idle level follows polarity
    always_comb begin
        pins = noise;
        pins[sel_a] = lvl[1] ^ pol;
        pins[sel_b] = lvl[0] ^ pol;
    end
endmodule
`default_nettype wire

// ==== sim/quadrature_wheel_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module quadrature_wheel_decoder_tb
    import wheel_decoder_pkg::*;
;
    localparam int HOLD = 80;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic [7:0] RDATA;
    logic [7:0] pins;
    logic [2:0] sel_a = 3'h0;
    logic [2:0] sel_b = 3'h1;
    logic pol = 1'b0;
    logic [1:0] lvl = 2'h0;
    int errors = 0;
    int n_compared = 0;
    // Quadrature order from idle, forward and backward
    logic [1:0] fwd [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    logic [1:0] bwd [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    // Slow clock shrunk to 4 cycles so filter windows stay short
    quadrature_wheel_decoder #(.SLOW_DIVIDE(4), .WINDOW_SAMPLES(FILTER_SAMPLES)) dut_u (
        .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .PHASE_PIN(pins), .RDATA(RDATA));
    wheel_encoder enc_u (.clk(MCLK), .sel_a(sel_a), .sel_b(sel_b), .pol(pol), .lvl(lvl),
        .pins(pins));
    // 20 MHz clock
    always #25 MCLK = ~MCLK;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge MCLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= v;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge MCLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        #1;
        check(what, RDATA, exp);
    endtask
    task automatic ld_chk(input logic [7:0] exp, input string what);
        wr(8'hD8, 8'h01);
        rd_chk(8'hD0, exp, what);
    endtask
    // Hold the counter at zero long enough for the filters to settle
    task automatic clr();
        wr(8'h60, 8'h20);
        repeat (HOLD) @(posedge MCLK);
        wr(8'h60, 8'h00);
    endtask
    task automatic walk(input bit back, input int edges);
        for (int i = 0; i < edges; i++) begin
            lvl <= back ? bwd[i % 4] : fwd[i % 4];
            repeat (HOLD) @(posedge MCLK);
        end
    endtask
    task automatic pulse(input logic [1:0] l, input int len);
        lvl <= l;
        repeat (len) @(posedge MCLK);
        lvl <= 2'h0;
        repeat (HOLD) @(posedge MCLK);
    endtask
    task automatic t_regs();
        logic [7:0] ra [7] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD6, 8'hD7, 8'hD8};
        logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
        for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i], "reset value");
        wr(8'hD1, 8'hFF);
        rd_chk(8'hD1, 8'h37, "setup mask");
        wr(8'hD6, 8'hFF);
        rd_chk(8'hD6, 8'h00, "reserved");
        wr(8'h55, 8'hFF);
        rd_chk(8'h55, 8'h00, "unmapped");
        wr(8'hD0, 8'hFF);
        rd_chk(8'hD0, 8'h00, "count write");
        wr(8'hD3, 8'hFE);
        rd_chk(8'hD3, 8'h06, "pin b");
        wr(8'hD1, 8'h00);
        wr(8'hD3, 8'h01);
        $display("done regs");
    endtask
    task automatic t_common();
        wr(8'hD7, 8'h00);
        clr();
        walk(1'b0, 4);
        ld_chk(8'h02, "common up");
        walk(1'b1, 8);
        ld_chk(8'hFE, "common down");
        $display("done common");
    endtask
    task automatic t_double();
        wr(8'hD7, 8'h01);
        clr();
        walk(1'b0, 8);
        wr(8'hD8, 8'h01);
        rd_chk(8'hD8, 8'h00, "load bit");
        rd_chk(8'hD0, 8'h08, "double up");
        rd_chk(8'hD0, 8'h00, "cleared");
        walk(1'b1, 12);
        rd_chk(8'hD0, 8'h00, "no load");
        ld_chk(8'hFC, "double wrap");
        wr(8'h60, 8'h20);
        ld_chk(8'h00, "held counter");
        wr(8'h60, 8'h00);
        $display("done double");
    endtask
    task automatic t_pins();
        for (int s = 0; s < 8; s++) begin
            wr(8'hD2, 8'(s));
            wr(8'hD3, 8'((s + 1) % 8));
            wr(8'hD1, s[0] ? 8'h10 : 8'h00);
            sel_a <= 3'(s);
            sel_b <= 3'(s + 1);
            pol <= s[0];
            rd_chk(8'hD2, 8'(s), "pin a");
            clr();
            walk(1'b0, 4);
            ld_chk(8'h04, "pin walk");
        end
        $display("done pins");
    endtask
    task automatic t_glitch();
        wr(8'hD1, 8'h21);
        wr(8'hD2, 8'h00);
        wr(8'hD3, 8'h01);
        sel_a <= 3'h0;
        sel_b <= 3'h1;
        pol <= 1'b0;
        wr(8'hD7, 8'h00);
        clr();
        pulse(2'h2, 30);
        ld_chk(8'h00, "glitch");
        pulse(2'h2, HOLD);
        ld_chk(8'h01, "shuttle common");
        $display("done glitch");
    endtask
    task automatic t_shuttle();
        wr(8'hD1, 8'h20);
        wr(8'hD7, 8'h01);
        clr();
        pulse(2'h2, HOLD);
        pulse(2'h1, HOLD);
        pulse(2'h1, HOLD);
        ld_chk(8'hFE, "shuttle double");
        $display("done shuttle");
    endtask
    task automatic final_report();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge MCLK);
        RST <= 1'b0;
        t_regs();
        t_common();
        t_double();
        t_pins();
        t_glitch();
        t_shuttle();
        final_report();
    end
    // The tests need about 7100 cycles; over five times that means a hang
    initial begin
        repeat (40000) @(posedge MCLK);
        errors++;
        final_report();
    end
endmodule
`default_nettype wire
